// *** core/rsr_core.sv ***
// Purpose: Master status and soft reset register, plus hardware and terminal interrupt triplets with log counter.
// Assumes: Host requests arrive already deserialised from the host port, in the clk domain.
// Notes: Event inputs are same-domain one-cycle pulses from the protocol and init engines, except init_busy, a level held through init.
`timescale 1ns/1ps
// Notes on behaviour
// - Writing 1 to soft reset bit first clears execution start, then runs soft reset.
// - Soft reset bit reads 1 until done, then self-clears, ready rises, access returns.
// - During soft reset, ready pin and status bit 15 low, host access suspended.
// - While not ready, every host read returns the status register.
// - Status bits 9 to 5 and bit 3 always read zero.
// - Message-in-progress sets on valid command, clears at message end, resets zero.
// - Inhibited flag high while a bus is shut down by mode code.
// - Shutdown ends on override mode code, master reset, or soft reset request.
// - EEPROM checksum failure during init sets status bit 1 and hardware pending 14.
// - Init failure flags apply only when auto-init pin was 1 at reset release.
// - RAM word mismatch during init sets status bit 0 and hardware pending 13.
// - Interrupt count and 64-word circular log address register are provided.
// - Two three-register interrupt groups exist, hardware and terminal.
// - Same bit position in enable, pending, output enable means the same event.
// - Events with enable bit 0 are ignored: no pending, no log, no output.
// - Enabling a bit later never recognises events from while it was clear.
// - Pending register latches each enabled event occurrence.
// - Interrupt output asserts for enabled event only when its output enable is set.
// - Host read of hardware pending register clears it to zero.
// - One active-low interrupt output is shared by both groups.
// - Ready low also during auto-init and built-in test, with access locked out.
module rsr_core #(
	parameter int unsigned SRST_LEN = rsr_pkg::SRST_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic auto_init_enable_pin,
	input wire rsr_pkg::rsr_req_t req,
	input wire rsr_pkg::rsr_evt_t evt,
	input wire logic [rsr_pkg::DW-1:0] hw_evt,
	input wire logic [rsr_pkg::DW-1:0] rt_evt,
	output logic [rsr_pkg::DW-1:0] rdata,
	output logic ready,
	output logic irq_n,
	output logic execution_start_bit,
	output logic soft_reset_active,
	output logic log_wr
);
	logic [rsr_pkg::DW-1:0] hw_en_reg;
	logic [rsr_pkg::DW-1:0] hw_oe_reg;
	logic [rsr_pkg::DW-1:0] hw_pend_reg;
	logic [rsr_pkg::DW-1:0] rt_en_reg;
	logic [rsr_pkg::DW-1:0] rt_oe_reg;
	logic [rsr_pkg::DW-1:0] rt_pend_reg;
	logic [rsr_pkg::DW-1:0] hw_en_next;
	logic [rsr_pkg::DW-1:0] hw_oe_next;
	logic [rsr_pkg::DW-1:0] hw_pend_next;
	logic [rsr_pkg::DW-1:0] rt_en_next;
	logic [rsr_pkg::DW-1:0] rt_oe_next;
	logic [rsr_pkg::DW-1:0] rt_pend_next;
	logic [6:0] log_cnt_reg;
	logic [6:0] log_cnt_next;
	logic [4:0] log_ptr_reg;
	logic [4:0] log_ptr_next;
	logic mip_reg;
	logic inh_reg;
	logic cke_reg;
	logic ram_init_mismatch_flag_reg;
	logic auto_init_enable_pin_reg;
	logic exec_reg;
	logic srst_reg;
	logic mip_next;
	logic inh_next;
	logic cke_next;
	logic ram_init_mismatch_flag_next;
	logic exec_next;
	logic srst_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	rsr_pkg::rsr_state_t st_reg;
	rsr_pkg::rsr_state_t st_next;
	logic [rsr_pkg::DW-1:0] status_word;
	logic [rsr_pkg::DW-1:0] hw_raw;
	logic [rsr_pkg::DW-1:0] rt_raw;
	logic [rsr_pkg::DW-1:0] hw_hit;
	logic [rsr_pkg::DW-1:0] rt_hit;
	logic [rsr_pkg::DW-1:0] hw_view;
	logic [rsr_pkg::DW-1:0] rd_mux;
	logic rd_ok;
	logic wr_ok;
	logic srst_req;
	logic srst_done;
	logic any_hit;
	logic hw_rd;
	logic rt_rd;
	logic log_rd;

	assign ready = ~srst_reg & ~evt.init_busy;
	assign soft_reset_active = srst_reg;
	assign execution_start_bit = exec_reg;
	assign rd_ok = ce & req.rd & ready;
	assign wr_ok = ce & req.wr & ready;
	assign srst_req = wr_ok && req.addr == rsr_pkg::OFS_STATUS && req.wdata[rsr_pkg::B_SRST];
	assign srst_done = st_reg == rsr_pkg::ST_RUN && cnt_reg == 16'(SRST_LEN - 1);

	// unused bits are tied to zero in the concatenation.
	assign status_word = {ready, 1'b0, auto_init_enable_pin_reg, 2'b00, srst_reg, 5'h00, mip_reg, 1'b0, inh_reg, cke_reg,
		ram_init_mismatch_flag_reg};

	// init failures only count when auto-init was strapped at reset.
	assign hw_raw = hw_evt | ({16{auto_init_enable_pin_reg & evt.cke_fail}} & (16'h0001 << rsr_pkg::HW_CKE))
		| ({16{auto_init_enable_pin_reg & evt.ram_fail}} & (16'h0001 << rsr_pkg::HW_RAM_INIT_MISMATCH_FLAG));
	assign rt_raw = rt_evt;
	assign hw_hit = hw_raw & hw_en_reg;
	assign rt_hit = rt_raw & rt_en_reg;
	assign any_hit = |{hw_hit, rt_hit};
	assign log_wr = ce & any_hit;
	assign hw_view = hw_pend_reg | ((rt_pend_reg != '0) ? (16'h0001 << rsr_pkg::HW_RTIP) : 16'h0000);
	assign hw_rd = rd_ok && req.addr == rsr_pkg::OFS_HW_PEND;
	assign rt_rd = rd_ok && req.addr == rsr_pkg::OFS_RT_PEND;
	assign log_rd = rd_ok && req.addr == rsr_pkg::OFS_LOG;
	assign irq_n = ~(|(hw_pend_reg & hw_oe_reg) | |(rt_pend_reg & rt_oe_reg));

	always_comb begin
		case (req.addr)
			rsr_pkg::OFS_CONFIG: rd_mux = {15'h0000, exec_reg};
			rsr_pkg::OFS_STATUS: rd_mux = status_word;
			rsr_pkg::OFS_HW_PEND: rd_mux = hw_view;
			rsr_pkg::OFS_RT_PEND: rd_mux = rt_pend_reg;
			rsr_pkg::OFS_LOG: rd_mux = {log_cnt_reg, rsr_pkg::LOG_BASE | {3'b000, log_ptr_reg, 1'b0}};
			rsr_pkg::OFS_HW_EN: rd_mux = hw_en_reg;
			rsr_pkg::OFS_HW_OE: rd_mux = hw_oe_reg;
			rsr_pkg::OFS_RT_EN: rd_mux = rt_en_reg;
			rsr_pkg::OFS_RT_OE: rd_mux = rt_oe_reg;
			default: rd_mux = 16'h0000;
		endcase
	end

	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		srst_next = srst_reg;
		exec_next = exec_reg;
		if (wr_ok && req.addr == rsr_pkg::OFS_CONFIG)
			exec_next = req.wdata[rsr_pkg::B_EXEC];
		case (st_reg)
			rsr_pkg::ST_IDLE: begin
				if (srst_req) begin
					srst_next = 1'b1;
					st_next = rsr_pkg::ST_STOP;
				end
			end
			rsr_pkg::ST_STOP: begin
				exec_next = 1'b0;
				cnt_next = 16'h0000;
				st_next = rsr_pkg::ST_RUN;
			end
			rsr_pkg::ST_RUN: begin
				cnt_next = cnt_reg + 16'h0001;
				if (srst_done) begin
					srst_next = 1'b0;
					st_next = rsr_pkg::ST_IDLE;
				end
			end
			default: st_next = rsr_pkg::ST_IDLE;
		endcase
	end

	always_comb begin
		// Set wins over the message-end clear so a back-to-back command is not lost.
		mip_next = evt.cmd_valid | (mip_reg & ~evt.msg_done);
		// shutdown entry wins over override in the same cycle.
		inh_next = evt.shutdown | (inh_reg & ~evt.override & ~srst_req);
		cke_next = cke_reg | (auto_init_enable_pin_reg & evt.cke_fail);
		ram_init_mismatch_flag_next = ram_init_mismatch_flag_reg | (auto_init_enable_pin_reg & evt.ram_fail);
		// Read clears, but a same-cycle hit survives the clear.
		hw_pend_next = (hw_rd ? 16'h0000 : hw_pend_reg) | hw_hit;
		rt_pend_next = (rt_rd ? 16'h0000 : rt_pend_reg) | rt_hit;
		hw_en_next = (wr_ok && req.addr == rsr_pkg::OFS_HW_EN) ? req.wdata : hw_en_reg;
		hw_oe_next = (wr_ok && req.addr == rsr_pkg::OFS_HW_OE) ? req.wdata : hw_oe_reg;
		rt_en_next = (wr_ok && req.addr == rsr_pkg::OFS_RT_EN) ? req.wdata : rt_en_reg;
		rt_oe_next = (wr_ok && req.addr == rsr_pkg::OFS_RT_OE) ? req.wdata : rt_oe_reg;
		log_ptr_next = any_hit ? log_ptr_reg + 5'h01 : log_ptr_reg;
		log_cnt_next = log_rd ? 7'h00 : log_cnt_reg;
		if (any_hit && log_cnt_next != rsr_pkg::LOG_CNT_MAX)
			log_cnt_next = log_cnt_next + 7'h01;
	end

	// Not-ready reads see the status word at any address.
	always_ff @(posedge clk) begin
		if (!rstn)
			rdata <= 16'h0000;
		else if (ce && req.rd)
			rdata <= ready ? rd_mux : status_word;
	end

	// The strap is a pin, so it crosses two flops before the capture reads it.
	logic strap_meta;
	logic strap_sync;
	always_ff @(posedge clk) begin
		if (ce) begin
			strap_meta <= auto_init_enable_pin;
			strap_sync <= strap_meta;
		end
	end

	// The strap is caught on the first enabled edge after reset release, never under reset.
	// Limitation: the strap must be steady for two enabled edges before reset is released.
	logic strap_seen;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			strap_seen <= 1'b0;
			auto_init_enable_pin_reg <= 1'b0;
		end else if (ce && !strap_seen) begin
			strap_seen <= 1'b1;
			auto_init_enable_pin_reg <= strap_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg <= rsr_pkg::ST_IDLE;
			cnt_reg <= 16'h0000;
			srst_reg <= 1'b0;
			exec_reg <= 1'b0;
			mip_reg <= 1'b0;
			inh_reg <= 1'b0;
			cke_reg <= 1'b0;
			ram_init_mismatch_flag_reg <= 1'b0;
		end else if (ce) begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			srst_reg <= srst_next;
			exec_reg <= exec_next;
			mip_reg <= mip_next;
			inh_reg <= inh_next;
			cke_reg <= cke_next;
			ram_init_mismatch_flag_reg <= ram_init_mismatch_flag_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			hw_en_reg <= rsr_pkg::HW_EN_RESET;
			hw_oe_reg <= 16'h0000;
			hw_pend_reg <= 16'h0000;
			rt_en_reg <= 16'h0000;
			rt_oe_reg <= 16'h0000;
			rt_pend_reg <= 16'h0000;
			log_cnt_reg <= 7'h00;
			log_ptr_reg <= 5'h00;
		end else if (ce) begin
			hw_en_reg <= hw_en_next;
			hw_oe_reg <= hw_oe_next;
			hw_pend_reg <= hw_pend_next;
			rt_en_reg <= rt_en_next;
			rt_oe_reg <= rt_oe_next;
			rt_pend_reg <= rt_pend_next;
			log_cnt_reg <= log_cnt_next;
			log_ptr_reg <= log_ptr_next;
		end
	end

	// Soft reset sequencing and host lock-out.
	chk_exec_cleared: assert property (@(posedge clk) disable iff (!rstn)
		ce && st_reg == rsr_pkg::ST_STOP |=> !execution_start_bit) else $error("exec bit not cleared");
	chk_srst_enter: assert property (@(posedge clk) disable iff (!rstn)
		ce && srst_req |=> srst_reg && st_reg == rsr_pkg::ST_STOP) else $error("soft reset not entered");
	chk_srst_ready_low: assert property (@(posedge clk) disable iff (!rstn)
		srst_reg |-> !ready && !status_word[rsr_pkg::B_READY]) else $error("ready high in reset");
	chk_write_locked: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.wr && !ready |=> $stable(hw_en_reg) && $stable(hw_oe_reg) && $stable(rt_en_reg))
		else $error("write taken while busy");
	chk_notready_read: assert property (@(posedge clk) disable iff (!rstn)
		ce && req.rd && !ready |=> rdata == $past(status_word)) else $error("wrong read while busy");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (!rstn)
		status_word[9:5] == 5'h00 && !status_word[3] && !status_word[14]) else $error("reserved set");
	chk_srst_len: assert property (@(posedge clk) disable iff (!rstn)
		ce && srst_done |=> !srst_reg && ready == !evt.init_busy) else $error("soft reset end");

	// Status flags.
	chk_mip_set: assert property (@(posedge clk) disable iff (!rstn)
		ce && evt.cmd_valid |=> mip_reg) else $error("mip not set");
	chk_mip_clear: assert property (@(posedge clk) disable iff (!rstn)
		ce && evt.msg_done && !evt.cmd_valid |=> !mip_reg) else $error("mip not cleared");
	chk_inh_set: assert property (@(posedge clk) disable iff (!rstn)
		ce && evt.shutdown |=> inh_reg) else $error("inhibit not set");
	chk_inh_end: assert property (@(posedge clk) disable iff (!rstn)
		ce && evt.override && !evt.shutdown |=> !inh_reg) else $error("inhibit not ended");
	chk_inh_srst: assert property (@(posedge clk) disable iff (!rstn)
		ce && srst_req && !evt.shutdown |=> !inh_reg) else $error("inhibit kept over soft reset");
	chk_cke_set: assert property (@(posedge clk) disable iff (!rstn)
		ce && auto_init_enable_pin_reg && evt.cke_fail |=> cke_reg) else $error("checksum flag not set");
	chk_flag_strap: assert property (@(posedge clk) disable iff (!rstn)
		!auto_init_enable_pin_reg && strap_seen && !cke_reg |=> !cke_reg) else $error("cke without strap");
	chk_strap_hold: assert property (@(posedge clk) disable iff (!rstn)
		strap_seen |=> $stable(auto_init_enable_pin_reg)) else $error("strap changed after capture");
	chk_ram_init_mismatch_flag_set: assert property (@(posedge clk) disable iff (!rstn)
		ce && auto_init_enable_pin_reg && evt.ram_fail |=> ram_init_mismatch_flag_reg) else $error("ram mismatch flag not set");

	// Interrupt gating, pending and log count.
	chk_log_step: assert property (@(posedge clk) disable iff (!rstn)
		ce && any_hit && !log_rd && log_cnt_reg != rsr_pkg::LOG_CNT_MAX |=> log_cnt_reg == $past(log_cnt_reg) + 7'h01)
		else $error("log count not advanced");
	chk_gate_off: assert property (@(posedge clk) disable iff (!rstn)
		ce && !hw_hit[5] && !hw_pend_reg[5] |=> !hw_pend_reg[5]) else $error("disabled event latched");
	chk_pend_latch: assert property (@(posedge clk) disable iff (!rstn)
		ce && hw_hit[5] |=> hw_pend_reg[5]) else $error("enabled event not latched");
	chk_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
		!irq_n |-> |(hw_pend_reg & hw_oe_reg) || |(rt_pend_reg & rt_oe_reg)) else $error("irq not gated");
	chk_pend_clear: assert property (@(posedge clk) disable iff (!rstn)
		ce && hw_rd && hw_hit == '0 |=> hw_pend_reg == '0) else $error("pending not cleared");
	chk_rt_clear: assert property (@(posedge clk) disable iff (!rstn)
		ce && rt_rd && rt_hit == '0 |=> rt_pend_reg == '0) else $error("terminal pending not cleared");
	chk_irq_assert: assert property (@(posedge clk) disable iff (!rstn)
		(|(hw_pend_reg & hw_oe_reg) || |(rt_pend_reg & rt_oe_reg)) |-> !irq_n) else $error("irq not raised");
endmodule

// *** core/rsr_pkg.sv ***
// Purpose: Shared constants and types for the terminal status, soft reset and interrupt gating block.
// Assumes: Register offsets and word widths as mapped for the device's host port.
// Notes: All timing is in device clock cycles.
package rsr_pkg;
	localparam int unsigned DW = 16;
	localparam int unsigned AW = 16;
	localparam logic [AW-1:0] OFS_CONFIG = 16'h0000;
	localparam logic [AW-1:0] OFS_STATUS = 16'h0001;
	localparam logic [AW-1:0] OFS_HW_PEND = 16'h0006;
	localparam logic [AW-1:0] OFS_RT_PEND = 16'h0009;
	localparam logic [AW-1:0] OFS_LOG = 16'h000a;
	localparam logic [AW-1:0] OFS_HW_EN = 16'h000f;
	localparam logic [AW-1:0] OFS_HW_OE = 16'h0013;
	localparam logic [AW-1:0] OFS_RT_EN = 16'h0014;
	localparam logic [AW-1:0] OFS_RT_OE = 16'h0015;
	localparam int unsigned B_READY = 15;
	localparam int unsigned B_AUTO_INIT_ENABLE_PIN = 13;
	localparam int unsigned B_SRST = 10;
	localparam int unsigned B_MIP = 4;
	localparam int unsigned B_INH = 2;
	localparam int unsigned B_CKE = 1;
	localparam int unsigned B_RAM_INIT_MISMATCH_FLAG = 0;
	localparam int unsigned B_EXEC = 0;
	localparam int unsigned HW_CKE = 14;
	localparam int unsigned HW_RAM_INIT_MISMATCH_FLAG = 13;
	localparam int unsigned HW_RTIP = 2;
	localparam logic [DW-1:0] HW_EN_RESET = 16'h6000;
	localparam logic [8:0] LOG_BASE = 9'h180;
	localparam logic [6:0] LOG_CNT_MAX = 7'h7f;
	localparam int unsigned SRST_CYCLES = 16;
	localparam logic [DW-1:0] STATUS_RW_MASK = 16'h0400;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} rsr_req_t;
	typedef struct packed {
		logic cmd_valid;
		logic msg_done;
		logic shutdown;
		logic override;
		logic init_busy;
		logic cke_fail;
		logic ram_fail;
	} rsr_evt_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_STOP = 2'b01,
		ST_RUN = 2'b10
	} rsr_state_t;
endpackage

// *** tb/rsr_host.sv ***
// Purpose: Host side model that issues register reads and writes to the block.
// Assumes: One request per cycle, changed only at the falling clock edge.
// Notes: Each request is held across exactly one rising edge, so back to back calls never overlap.
`timescale 1ns/1ps
module rsr_host (
	input wire logic clk,
	input wire logic [rsr_pkg::DW-1:0] rdata,
	output rsr_pkg::rsr_req_t req
);
	initial req = '0;
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(negedge clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
		@(negedge clk) req <= '0;
	endtask
	// Read data is registered at the accepting edge, so it is taken at the following falling edge.
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(negedge clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(negedge clk) v = rdata;
		req <= '0;
	endtask
endmodule

// *** tb/rt_status_reset_irq_gating_test.sv ***
// Purpose: Self-checking bench for status, soft reset and interrupt gating.
// Assumes: Soft reset length shortened to 4 cycles, strap high until the last reset.
// Notes: Events are driven at the falling edge; log_wr is sampled 1 ns later, other results after the next rising edge.
`timescale 1ns/1ps
module rt_status_reset_irq_gating_test;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic strap = 1'b1;
	logic ce = 1'b1;
	rsr_pkg::rsr_req_t req;
	rsr_pkg::rsr_evt_t evt = '0;
	logic [15:0] hw_evt = '0;
	logic [15:0] rt_evt = '0;
	logic [15:0] rdata, d;
	logic ready, irq_n, exec, srst, log_wr, lw;
	int bad_count = 0;
	int samples_checked = 0;
	always #50 clk = ~clk;
	rsr_core #(.SRST_LEN(4)) dut (.clk(clk), .rstn(rstn), .ce(ce), .auto_init_enable_pin(strap),
		.req(req), .evt(evt), .hw_evt(hw_evt), .rt_evt(rt_evt), .rdata(rdata), .ready(ready),
		.irq_n(irq_n), .execution_start_bit(exec), .soft_reset_active(srst), .log_wr(log_wr));
	rsr_host host (.clk(clk), .rdata(rdata), .req(req));
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		host.rd(a, d);
		cmp(d, exp);
	endtask
	task automatic pulse(input rsr_pkg::rsr_evt_t e, input logic [15:0] h, input logic [15:0] r);
		@(negedge clk);
		evt = e;
		hw_evt = h;
		rt_evt = r;
		#1 lw = log_wr;
		@(negedge clk);
		evt = '0;
		hw_evt = '0;
		rt_evt = '0;
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 50; i++) begin
			@(negedge clk);
			if (ready === 1'b1) return;
		end
		bad_count++;
		report_and_stop();
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha000);
		rd_chk(rsr_pkg::OFS_HW_EN, rsr_pkg::HW_EN_RESET);
		rd_chk(rsr_pkg::OFS_LOG, 16'h0180);
		host.wr(rsr_pkg::OFS_STATUS, 16'hfbff);
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha000);
		pulse(7'h00, 16'h0020, 16'h0000);
		cmp_bit(lw, 1'b0);
		host.wr(rsr_pkg::OFS_HW_EN, 16'h6020);
		rd_chk(rsr_pkg::OFS_HW_PEND, 16'h0000);
		pulse(7'h00, 16'h0020, 16'h0000);
		cmp_bit(lw, 1'b1);
		cmp_bit(irq_n, 1'b1);
		host.wr(rsr_pkg::OFS_HW_OE, 16'h0020);
		cmp_bit(irq_n, 1'b0);
		rd_chk(rsr_pkg::OFS_HW_PEND, 16'h0020);
		rd_chk(rsr_pkg::OFS_HW_PEND, 16'h0000);
		cmp_bit(irq_n, 1'b1);
		// With the clock enable low a write must leave every register untouched.
		ce = 1'b0;
		host.wr(rsr_pkg::OFS_HW_OE, 16'h0000);
		ce = 1'b1;
		rd_chk(rsr_pkg::OFS_HW_OE, 16'h0020);
		host.wr(rsr_pkg::OFS_RT_EN, 16'h0008);
		host.wr(rsr_pkg::OFS_RT_OE, 16'h0008);
		pulse(7'h00, 16'h0000, 16'h0018);
		cmp_bit(irq_n, 1'b0);
		rd_chk(rsr_pkg::OFS_HW_PEND, 16'h0004);
		rd_chk(rsr_pkg::OFS_RT_PEND, 16'h0008);
		pulse(7'h40, 16'h0000, 16'h0000);
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha010);
		pulse(7'h20, 16'h0000, 16'h0000);
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha000);
		pulse(7'h10, 16'h0000, 16'h0000);
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha004);
		pulse(7'h08, 16'h0000, 16'h0000);
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha000);
		pulse(7'h10, 16'h0000, 16'h0000);
		host.wr(rsr_pkg::OFS_CONFIG, 16'h0001);
		cmp_bit(exec, 1'b1);
		host.wr(rsr_pkg::OFS_STATUS, 16'h0400);
		cmp_bit(ready, 1'b0);
		cmp_bit(srst, 1'b1);
		host.wr(rsr_pkg::OFS_HW_EN, 16'h0000);
		rd_chk(rsr_pkg::OFS_HW_PEND, 16'h2400);
		cmp_bit(exec, 1'b0);
		wait_ready();
		cmp_bit(srst, 1'b0);
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha000);
		rd_chk(rsr_pkg::OFS_HW_EN, 16'h6020);
		evt = 7'h04;
		rd_chk(rsr_pkg::OFS_LOG, 16'h2000);
		evt = '0;
		pulse(7'h02, 16'h0000, 16'h0000);
		pulse(7'h01, 16'h0000, 16'h0000);
		rd_chk(rsr_pkg::OFS_STATUS, 16'ha003);
		rd_chk(rsr_pkg::OFS_HW_PEND, 16'h6000);
		rd_chk(rsr_pkg::OFS_LOG, 16'h0988);
		// A fresh reset with the strap low shows that init failures are then ignored.
		rstn = 1'b0;
		strap = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		pulse(7'h03, 16'h0000, 16'h0000);
		rd_chk(rsr_pkg::OFS_STATUS, 16'h8000);
		report_and_stop();
	end
endmodule
